// ### logic/usart_core.v
`timescale 1ns/1ps
`include "usart_defines.vh"
module usart_core (
    input  wire        SYS_CLK,
    input  wire        NRST,
    input  wire        SYNC_MODE_SELECT,
    input  wire        DOUBLE_SPEED,
    input  wire        TRANSFER_CLOCK_DIRECTION,
    input  wire        SYNC_CLOCK_POLARITY,
    input  wire [2:0]  CHAR_SIZE,
    input  wire [1:0]  PARITY_MODE,
    input  wire        TWO_STOP,
    input  wire        TX_ENABLE,
    input  wire        RX_ENABLE,
    input  wire [3:0]  BAUD_DIVISOR_HIGH,
    input  wire [7:0]  BAUD_DIVISOR_LOW,
    input  wire        BAUD_LOW_WRITE,
    input  wire [8:0]  TX_DATA,
    input  wire        TX_WRITE,
    input  wire        TX_DONE_CLEAR,
    input  wire        RX_READ,
    output wire [8:0]  RX_DATA,
    output wire        RX_FRAME_ERROR,
    output wire        RX_OVERRUN,
    output wire        RX_PARITY_ERROR,
    output wire        TX_DONE_IRQ,
    output wire        TX_EMPTY_IRQ,
    output wire        RX_DONE_IRQ,
    input  wire        RXD_PIN,
    output wire        TXD_PIN,
    input  wire        XCK_IN,
    output wire        XCK_OUT,
    output wire        XCK_OE_N
);
    localparam [2:0] S_IDLE  = 3'b000;
    localparam [2:0] S_START = 3'b001;
    localparam [2:0] S_DATA  = 3'b010;
    localparam [2:0] S_PAR   = 3'b011;
    localparam [2:0] S_STOP1 = 3'b100;
    localparam [2:0] S_STOP2 = 3'b101;

    reg  [1:0]  rst_q;
    wire        rst_n;
    wire        sync_mode;
    wire        dbl;
    wire        master;
    wire        slave;
    wire        tick;
    wire [3:0]  last;
    wire [3:0]  half;
    wire [3:0]  nbits;
    wire        par_on;
    wire        par_init;
    reg         xck_s1_q;
    reg         xck_s2_q;
    reg         xck_s3_q;
    reg         xck_q;
    wire        clk_rise;
    wire        clk_fall;
    wire        change_edge;
    wire        sample_edge;
    reg  [3:0]  tx_pre_q;
    wire        tx_en;
    reg  [2:0]  tx_st_q;
    reg  [8:0]  tx_buf_q;
    reg         tx_bv_q;
    reg  [8:0]  tx_sh_q;
    reg  [3:0]  tx_cnt_q;
    reg         tx_par_q;
    reg         tx_line_q;
    reg         tx_done_q;
    wire        tx_load;
    wire        tx_finish;
    reg         rx_s1_q;
    reg         rx_s2_q;
    reg  [2:0]  rx_hist_q;
    wire        rx_line;
    reg  [3:0]  rx_pre_q;
    wire        rx_smp;
    reg  [2:0]  rx_st_q;
    reg  [8:0]  rx_sh_q;
    reg  [3:0]  rx_cnt_q;
    reg         rx_par_q;
    reg         rx_fe_q;
    reg         rx_pe_q;
    reg         rx_dor_q;
    reg         rx_pend_q;
    wire        start_seen;
    wire        fifo_full;
    wire        fifo_empty;
    wire        push;
    wire [8:0]  rx_aligned;
    wire [`ENT_W-1:0] entry;
    wire [`ENT_W-1:0] head;

    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    assign sync_mode = SYNC_MODE_SELECT;
    assign dbl    = DOUBLE_SPEED && !sync_mode;
    assign master = sync_mode && TRANSFER_CLOCK_DIRECTION;
    assign slave  = sync_mode && !TRANSFER_CLOCK_DIRECTION;
    assign last   = dbl ? `LAST_DOUBLE : `LAST_NORMAL;
    assign half   = dbl ? `HALF_DOUBLE : `HALF_NORMAL;
    assign nbits  = (CHAR_SIZE == `CSZ_NINE) ? `NBITS_NINE :
                    (`NBITS_BASE + {1'b0, CHAR_SIZE});
    assign par_on   = PARITY_MODE[1];
    assign par_init = (PARITY_MODE == `PAR_ODD);

    baud_gen #(
        .W(`BAUD_W)
    ) u_baud (
        .clk       (SYS_CLK),
        .rst_n     (rst_n),
        .divisor   ({BAUD_DIVISOR_HIGH, BAUD_DIVISOR_LOW}),
        .low_write (BAUD_LOW_WRITE),
        .tick      (tick)
    );

    // The pin feeds two flops before the edge detector looks at it.
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            xck_s1_q <= 1'b0;
            xck_s2_q <= 1'b0;
            xck_s3_q <= 1'b0;
            xck_q    <= 1'b0;
        end else begin
            xck_s1_q <= XCK_IN;
            xck_s2_q <= xck_s1_q;
            xck_s3_q <= xck_s2_q;
            if (!master) begin
                xck_q <= SYNC_CLOCK_POLARITY;
            end else if (tick) begin
                xck_q <= !xck_q;
            end
        end
    end
    // Slave edges arrive two cycles late, so the partner must stay
    // below a quarter of the system clock.
    assign clk_rise = master ? (tick && !xck_q)
                    : (slave && xck_s2_q && !xck_s3_q);
    assign clk_fall = master ? (tick && xck_q)
                    : (slave && !xck_s2_q && xck_s3_q);
    assign change_edge = SYNC_CLOCK_POLARITY ? clk_fall : clk_rise;
    assign sample_edge = SYNC_CLOCK_POLARITY ? clk_rise : clk_fall;
    assign XCK_OUT  = xck_q;
    assign XCK_OE_N = !master;

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            tx_pre_q <= 4'h0;
        end else if (tick) begin
            tx_pre_q <= (tx_pre_q >= last) ? 4'h0 : tx_pre_q + 4'h1;
        end
    end
    assign tx_en = TX_ENABLE &&
                   (sync_mode ? change_edge
                              : (tick && tx_pre_q >= last));

    assign tx_finish = tx_en && ((tx_st_q == S_STOP2) ||
                       (tx_st_q == S_STOP1 && !TWO_STOP));
    assign tx_load = tx_en && tx_bv_q &&
                     (tx_st_q == S_IDLE || tx_finish);

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            tx_st_q   <= S_IDLE;
            tx_buf_q  <= 9'h000;
            tx_bv_q   <= 1'b0;
            tx_sh_q   <= 9'h000;
            tx_cnt_q  <= 4'h0;
            tx_par_q  <= 1'b0;
            tx_line_q <= 1'b1;
            tx_done_q <= 1'b0;
        end else begin
            if (TX_WRITE && (!tx_bv_q || tx_load)) begin
                tx_buf_q <= TX_DATA;
                tx_bv_q  <= 1'b1;
            end else if (tx_load) begin
                tx_bv_q <= 1'b0;
            end
            if (tx_finish && !tx_bv_q) begin
                tx_done_q <= 1'b1;
            end else if (TX_DONE_CLEAR) begin
                tx_done_q <= 1'b0;
            end
            if (!TX_ENABLE) begin
                tx_st_q   <= S_IDLE;
                tx_line_q <= 1'b1;
            end else if (tx_load) begin
                tx_line_q <= 1'b0;
                tx_sh_q   <= tx_buf_q;
                tx_cnt_q  <= 4'h0;
                tx_par_q  <= par_init;
                tx_st_q   <= S_START;
            end else if (tx_en) begin
                case (tx_st_q)
                    S_START, S_DATA: begin
                        if (tx_cnt_q == nbits) begin
                            tx_line_q <= par_on ? tx_par_q : 1'b1;
                            tx_st_q   <= par_on ? S_PAR : S_STOP1;
                        end else begin
                            tx_line_q <= tx_sh_q[0];
                            tx_sh_q   <= {1'b0, tx_sh_q[8:1]};
                            tx_par_q  <= tx_par_q ^ tx_sh_q[0];
                            tx_cnt_q  <= tx_cnt_q + 4'h1;
                            tx_st_q   <= S_DATA;
                        end
                    end
                    S_PAR: begin
                        tx_line_q <= 1'b1;
                        tx_st_q   <= S_STOP1;
                    end
                    S_STOP1: begin
                        tx_line_q <= 1'b1;
                        tx_st_q   <= TWO_STOP ? S_STOP2 : S_IDLE;
                    end
                    S_STOP2: begin
                        tx_st_q <= S_IDLE;
                    end
                    default: begin
                        tx_line_q <= 1'b1;
                        tx_st_q   <= S_IDLE;
                    end
                endcase
            end
        end
    end
    assign TXD_PIN      = tx_line_q;
    assign TX_DONE_IRQ  = tx_done_q;
    assign TX_EMPTY_IRQ = !tx_bv_q;

    // The three-sample majority costs one tick of latency but drops
    // single-tick spikes on the line.
    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rx_s1_q   <= 1'b1;
            rx_s2_q   <= 1'b1;
            rx_hist_q <= 3'h7;
        end else begin
            rx_s1_q <= RXD_PIN;
            rx_s2_q <= rx_s1_q;
            if (tick) begin
                rx_hist_q <= {rx_hist_q[1:0], rx_s2_q};
            end
        end
    end
    assign rx_line = sync_mode ? rx_s2_q :
                     ((rx_hist_q[0] & rx_hist_q[1]) |
                      (rx_hist_q[1] & rx_hist_q[2]) |
                      (rx_hist_q[0] & rx_hist_q[2]));

    assign rx_smp = sync_mode ? sample_edge
                              : (tick && rx_pre_q >= last);
    assign start_seen = RX_ENABLE && (rx_st_q == S_IDLE) && !rx_line &&
                        (sync_mode ? sample_edge : tick);
    assign push = rx_pend_q && !fifo_full;
    assign rx_aligned = rx_sh_q >> (`NBITS_NINE - nbits);
    assign entry = {rx_pe_q, rx_dor_q, rx_fe_q, rx_aligned};

    always @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rx_st_q   <= S_IDLE;
            rx_pre_q  <= 4'h0;
            rx_sh_q   <= 9'h000;
            rx_cnt_q  <= 4'h0;
            rx_par_q  <= 1'b0;
            rx_fe_q   <= 1'b0;
            rx_pe_q   <= 1'b0;
            rx_dor_q  <= 1'b0;
            rx_pend_q <= 1'b0;
        end else begin
            if (push) begin
                rx_pend_q <= 1'b0;
                rx_dor_q  <= 1'b0;
            end else if (start_seen && rx_pend_q) begin
                rx_pend_q <= 1'b0;
                rx_dor_q  <= 1'b1;
            end
            if (tick) begin
                rx_pre_q <= (rx_pre_q >= last) ? 4'h0 : rx_pre_q + 4'h1;
            end
            if (!RX_ENABLE) begin
                rx_st_q <= S_IDLE;
            end else begin
                case (rx_st_q)
                    S_IDLE: begin
                        if (start_seen) begin
                            rx_cnt_q <= 4'h0;
                            rx_par_q <= par_init;
                            rx_pre_q <= 4'h0;
                            rx_st_q  <= sync_mode ? S_DATA : S_START;
                        end
                    end
                    S_START: begin
                        if (tick && rx_pre_q == half) begin
                            rx_pre_q <= 4'h0;
                            rx_st_q  <= rx_line ? S_IDLE : S_DATA;
                        end
                    end
                    S_DATA: begin
                        if (rx_smp) begin
                            rx_sh_q  <= {rx_line, rx_sh_q[8:1]};
                            rx_par_q <= rx_par_q ^ rx_line;
                            rx_cnt_q <= rx_cnt_q + 4'h1;
                            if (rx_cnt_q + 4'h1 == nbits) begin
                                rx_st_q <= par_on ? S_PAR : S_STOP1;
                            end
                        end
                    end
                    S_PAR: begin
                        if (rx_smp) begin
                            rx_pe_q <= rx_line ^ rx_par_q;
                            rx_st_q <= S_STOP1;
                        end
                    end
                    S_STOP1: begin
                        if (rx_smp) begin
                            rx_fe_q   <= !rx_line;
                            rx_pend_q <= 1'b1;
                            rx_st_q   <= S_IDLE;
                            if (!par_on) begin
                                rx_pe_q <= 1'b0;
                            end
                        end
                    end
                    default: begin
                        rx_st_q <= S_IDLE;
                    end
                endcase
            end
        end
    end

    rx_fifo #(
        .WIDTH (`ENT_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (1)
    ) u_fifo (
        .clk     (SYS_CLK),
        .rst_n   (rst_n),
        .push    (push),
        .wr_data (entry),
        .pop     (RX_READ),
        .rd_data (head),
        .full    (fifo_full),
        .empty   (fifo_empty)
    );
    assign RX_DATA         = head[8:0];
    assign RX_FRAME_ERROR  = head[`ENT_FE];
    assign RX_OVERRUN      = head[`ENT_DOR];
    assign RX_PARITY_ERROR = head[`ENT_PE];
    assign RX_DONE_IRQ     = !fifo_empty;
endmodule // usart_core

// ### logic/usart_defines.vh
// Contract
// - Four clock modes from sync, double-speed and direction bits.
// - Sync clock direction picks master or slave.
// - Transfer clock pin ignored in asynchronous modes.
// - Down-counter reloads at zero or low-byte write.
// - Baud tick each zero, rate clock over divisor+1.
// - Transmitter divides ticks by 16, 8 or 2.
// - Receiver recovery runs on ticks, 16/8 states.
// - Divisor is twelve bits, high and low bytes.
// - Double speed only acts in asynchronous mode.
// - Double speed receiver takes eight samples per bit.
// - One transmit buffer allows gapless back-to-back frames.
// - Receive buffer is two-entry circular FIFO, read once.
// - Error flags and ninth bit travel with data.
// - Full FIFO keeps character in shift register.
// - Receiver reports framing, overrun and parity errors.
// - Slave transfer clock is synchronized before use.
// - Three interrupt requests: tx done, empty, rx done.
// - Five to nine data bits, parity, 1-2 stops.
// - False start rejection and low-pass data filter.
// - Start low, LSB first, parity, high stops.
// - Parity is data XOR, inverted for odd.
// - Polarity selects change and sample clock edges.
`ifndef USART_DEFINES_VH
`define USART_DEFINES_VH
`define BAUD_W       12
`define LAST_NORMAL  4'hF
`define LAST_DOUBLE  4'h7
`define HALF_NORMAL  4'h7
`define HALF_DOUBLE  4'h3
`define PAR_EVEN     2'h2
`define PAR_ODD      2'h3
`define CSZ_NINE     3'h7
`define NBITS_BASE   4'h5
`define NBITS_NINE   4'h9
`define ENT_W        12
`define ENT_FE       9
`define ENT_DOR      10
`define ENT_PE       11
`define FIFO_DEPTH   2
`endif

// ### logic/baud_gen.v
`timescale 1ns/1ps
module baud_gen #(
    parameter W = 12
) (
    input  wire         clk,
    input  wire         rst_n,
    input  wire [W-1:0] divisor,
    input  wire         low_write,
    output wire         tick
);
    reg [W-1:0] cnt_q;

    assign tick = (cnt_q == {W{1'b0}});
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= {W{1'b0}};
        end else if (tick || low_write) begin
            cnt_q <= divisor;
        end else begin
            cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule // baud_gen

// ### logic/rx_fifo.v
`timescale 1ns/1ps
module rx_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 2,
    parameter AW    = 1
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             push,
    input  wire [WIDTH-1:0] wr_data,
    input  wire             pop,
    output wire [WIDTH-1:0] rd_data,
    output wire             full,
    output wire             empty
);
    // A sized step keeps the pointer sums free of zero-width parts.
    localparam [AW-1:0] PTR_STEP = 1;
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            do_push;
    wire            do_pop;

    assign full    = (cnt_q == DEPTH[AW:0]);
    assign empty   = (cnt_q == {(AW+1){1'b0}});
    assign do_push = push && !full;
    assign do_pop  = pop && !empty;
    assign rd_data = mem[rd_q];
    always @(posedge clk) begin
        if (do_push) begin
            mem[wr_q] <= wr_data;
        end
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (do_push) begin
                wr_q <= wr_q + PTR_STEP;
            end
            if (do_pop) begin
                rd_q <= rd_q + PTR_STEP;
            end
            if (do_push && !do_pop) begin
                cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
            end else if (do_pop && !do_push) begin
                cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
            end
        end
    end
endmodule // rx_fifo

// ### verification/usart_core_asserts.sv
`timescale 1ns/1ps
module usart_core_chk (
    input wire       SYS_CLK,
    input wire       NRST,
    input wire       SYNC_MODE_SELECT,
    input wire       TRANSFER_CLOCK_DIRECTION,
    input wire [1:0] PARITY_MODE,
    input wire       TX_WRITE,
    input wire       TX_DONE_CLEAR,
    input wire       RX_READ,
    input wire [8:0] RX_DATA,
    input wire       RX_FRAME_ERROR,
    input wire       RX_PARITY_ERROR,
    input wire       TX_DONE_IRQ,
    input wire       TX_EMPTY_IRQ,
    input wire       RX_DONE_IRQ,
    input wire       TXD_PIN,
    input wire       XCK_OE_N
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    property p_rst;
        $rose(NRST) |-> TXD_PIN && TX_EMPTY_IRQ &&
            !TX_DONE_IRQ && !RX_DONE_IRQ;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_async_oe;
        !SYNC_MODE_SELECT |-> XCK_OE_N;
    endproperty
    a_async_oe: assert property (p_async_oe) else $error("clock pin driven");
    property p_master_oe;
        SYNC_MODE_SELECT && TRANSFER_CLOCK_DIRECTION |-> !XCK_OE_N;
    endproperty
    a_master_oe: assert property (p_master_oe) else $error("no clock drive");
    property p_take;
        TX_WRITE && TX_EMPTY_IRQ |=> !TX_EMPTY_IRQ;
    endproperty
    a_take: assert property (p_take) else $error("write not taken");
    property p_stick;
        TX_DONE_IRQ && !TX_DONE_CLEAR |=> TX_DONE_IRQ;
    endproperty
    a_stick: assert property (p_stick) else $error("done flag lost");
    // Shortest legal bit is eight ticks of divisor zero, so seven holds.
    property p_bit;
        $changed(TXD_PIN) && !SYNC_MODE_SELECT |=> $stable(TXD_PIN) [*7];
    endproperty
    a_bit: assert property (p_bit) else $error("bit too short");
    property p_hold;
        RX_DONE_IRQ && !RX_READ |=> RX_DONE_IRQ && $stable(RX_DATA) &&
            $stable(RX_FRAME_ERROR) && $stable(RX_PARITY_ERROR);
    endproperty
    a_hold: assert property (p_hold) else $error("fifo head moved");
    property p_par_off;
        RX_DONE_IRQ && !PARITY_MODE[1] |-> !RX_PARITY_ERROR;
    endproperty
    a_par_off: assert property (p_par_off) else $error("parity flag");
endmodule // usart_core_chk
bind usart_core usart_core_chk rule_watch (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .SYNC_MODE_SELECT(SYNC_MODE_SELECT),
    .TRANSFER_CLOCK_DIRECTION(TRANSFER_CLOCK_DIRECTION),
    .PARITY_MODE(PARITY_MODE), .TX_WRITE(TX_WRITE), .RX_READ(RX_READ),
    .TX_DONE_CLEAR(TX_DONE_CLEAR), .RX_DATA(RX_DATA),
    .RX_FRAME_ERROR(RX_FRAME_ERROR), .RX_PARITY_ERROR(RX_PARITY_ERROR),
    .TX_DONE_IRQ(TX_DONE_IRQ), .TX_EMPTY_IRQ(TX_EMPTY_IRQ),
    .RX_DONE_IRQ(RX_DONE_IRQ), .TXD_PIN(TXD_PIN), .XCK_OE_N(XCK_OE_N)
);

// ### verification/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
    input  wire clk,
    input  wire txd,
    output reg  rxd
);
    integer cyc = 0;
    initial rxd = 1'b1;
    always @(posedge clk) begin
        cyc <= cyc + 1;
    end
    task send(input [8:0] d, input integer n, input [1:0] pm,
              input bad_par, input bad_stop, input integer bc);
        integer   i;
        reg [8:0] m;
        begin
            m = (9'h001 << n) - 9'h001;
            @(posedge clk) #1 rxd = 1'b0;
            repeat (bc) @(posedge clk);
            for (i = 0; i < n; i = i + 1) begin
                #1 rxd = d[i];
                repeat (bc) @(posedge clk);
            end
            if (pm[1]) begin
                #1 rxd = ^(d & m) ^ pm[0] ^ bad_par;
                repeat (bc) @(posedge clk);
            end
            #1 rxd = ~bad_stop;
            repeat (bc) @(posedge clk);
            #1 rxd = 1'b1;
        end
    endtask
    // Samples at mid-bit, so a frame with the wrong bit length is misread.
    task recv(output [8:0] d, output p, output s, output integer t0,
              input integer n, input integer bc);
        integer i;
        integer k;
        begin
            d = 9'h000;
            k = 0;
            while (txd !== 1'b0 && k < 100000) begin
                @(posedge clk);
                #1 k = k + 1;
            end
            t0 = cyc;
            repeat (bc / 2) @(posedge clk);
            for (i = 0; i < n; i = i + 1) begin
                repeat (bc) @(posedge clk);
                #1 d[i] = txd;
            end
            repeat (bc) @(posedge clk);
            #1 p = txd;
            repeat (bc) @(posedge clk);
            #1 s = txd;
        end
    endtask
endmodule // serial_peer

// ### verification/tb_usart_core.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        check_count = check_count + 1; \
        if ((g) !== (e)) begin \
            err_count = err_count + 1; \
            $display("ERROR %s expected %0h seen %0h", nm, e, g); \
        end \
    end
module tb_usart_core;
    reg        SYS_CLK = 1'b0;
    reg        NRST = 1'b0;
    reg        SYNC_MODE_SELECT = 1'b0;
    reg        DOUBLE_SPEED = 1'b0;
    reg        TRANSFER_CLOCK_DIRECTION = 1'b0;
    reg        SYNC_CLOCK_POLARITY = 1'b0;
    reg  [2:0] CHAR_SIZE = 3'h3;
    reg  [1:0] PARITY_MODE = 2'h2;
    reg        TWO_STOP = 1'b0;
    reg        TX_ENABLE = 1'b0;
    reg        RX_ENABLE = 1'b0;
    reg  [3:0] BAUD_DIVISOR_HIGH = 4'h0;
    reg  [7:0] BAUD_DIVISOR_LOW = 8'h03;
    reg        BAUD_LOW_WRITE = 1'b0;
    reg  [8:0] TX_DATA = 9'h000;
    reg        TX_WRITE = 1'b0;
    reg        TX_DONE_CLEAR = 1'b0;
    reg        RX_READ = 1'b0;
    reg        XCK_IN = 1'b0;
    reg  [8:0] m;
    reg        x0;
    wire [8:0] RX_DATA;
    wire       RX_FRAME_ERROR, RX_OVERRUN, RX_PARITY_ERROR;
    wire       TX_DONE_IRQ, TX_EMPTY_IRQ, RX_DONE_IRQ;
    wire       RXD_PIN, TXD_PIN, XCK_OUT, XCK_OE_N;
    wire [2:0] rx_flags = {RX_FRAME_ERROR, RX_PARITY_ERROR, RX_OVERRUN};
    wire [3:0] idle_state = {TXD_PIN, TX_EMPTY_IRQ, TX_DONE_IRQ, RX_DONE_IRQ};
    integer    err_count = 0;
    integer    check_count = 0;
    integer    n, k, bc, ta, tb2;
    always #25 SYS_CLK = ~SYS_CLK;
    // The pin keeps toggling in every mode; only slave mode may listen.
    always begin
        repeat (7) @(posedge SYS_CLK);
        #1 XCK_IN = ~XCK_IN;
    end
    usart_core DUT (
        .SYS_CLK(SYS_CLK), .NRST(NRST), .SYNC_MODE_SELECT(SYNC_MODE_SELECT),
        .DOUBLE_SPEED(DOUBLE_SPEED), .CHAR_SIZE(CHAR_SIZE),
        .TRANSFER_CLOCK_DIRECTION(TRANSFER_CLOCK_DIRECTION),
        .SYNC_CLOCK_POLARITY(SYNC_CLOCK_POLARITY), .TWO_STOP(TWO_STOP),
        .PARITY_MODE(PARITY_MODE), .TX_ENABLE(TX_ENABLE),
        .RX_ENABLE(RX_ENABLE), .BAUD_DIVISOR_HIGH(BAUD_DIVISOR_HIGH),
        .BAUD_DIVISOR_LOW(BAUD_DIVISOR_LOW), .BAUD_LOW_WRITE(BAUD_LOW_WRITE),
        .TX_DATA(TX_DATA), .TX_WRITE(TX_WRITE), .RX_READ(RX_READ),
        .TX_DONE_CLEAR(TX_DONE_CLEAR), .RX_DATA(RX_DATA),
        .RX_FRAME_ERROR(RX_FRAME_ERROR), .RX_OVERRUN(RX_OVERRUN),
        .RX_PARITY_ERROR(RX_PARITY_ERROR), .TX_DONE_IRQ(TX_DONE_IRQ),
        .TX_EMPTY_IRQ(TX_EMPTY_IRQ), .RX_DONE_IRQ(RX_DONE_IRQ),
        .RXD_PIN(RXD_PIN), .TXD_PIN(TXD_PIN), .XCK_IN(XCK_IN),
        .XCK_OUT(XCK_OUT), .XCK_OE_N(XCK_OE_N)
    );
    serial_peer PEER (.clk(SYS_CLK), .txd(TXD_PIN), .rxd(RXD_PIN));
    task summarize;
        begin
            $display("checks %0d mismatches %0d", check_count, err_count);
            if (err_count == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task step;
        begin
            @(posedge SYS_CLK);
            #1 k = k + 1;
        end
    endtask
    task wr(input [8:0] x);
        begin
            k = 0;
            while (TX_EMPTY_IRQ !== 1'b1 && k < 5000) step;
            TX_DATA = x;
            TX_WRITE = 1'b1;
            step;
            TX_WRITE = 1'b0;
        end
    endtask
    task txchk(input [8:0] x, output integer t);
        reg [8:0] d;
        reg       p;
        reg       s;
        begin
            PEER.recv(d, p, s, t, n, bc);
            `CHK("tx data", x & m, d)
            `CHK("tx parity", ^(x & m) ^ PARITY_MODE[0], p)
            `CHK("tx stop", 1'b1, s)
        end
    endtask
    // Status is taken before the pop, since the pop moves the head.
    task rd(input [8:0] x, input [2:0] e);
        begin
            k = 0;
            while (RX_DONE_IRQ !== 1'b1 && k < 5000) step;
            `CHK("rx data", x, RX_DATA)
            `CHK("rx flags", e, rx_flags)
            RX_READ = 1'b1;
            step;
            RX_READ = 1'b0;
            step;
        end
    endtask
    task wait_done;
        begin
            k = 0;
            while (TX_DONE_IRQ !== 1'b1 && k < 20000) step;
        end
    endtask
    task xck_edge(output integer t);
        begin
            x0 = XCK_OUT;
            k = 0;
            while (XCK_OUT === x0 && k < 2000) step;
            t = PEER.cyc;
        end
    endtask
    initial begin
        repeat (20) @(posedge SYS_CLK);
        `CHK("reset state", 4'hC, idle_state)
        #1 NRST = 1'b1;
        repeat (3) step;
        BAUD_LOW_WRITE = 1'b1;
        step;
        BAUD_LOW_WRITE = 1'b0;
        TX_ENABLE = 1'b1;
        RX_ENABLE = 1'b1;
        for (n = 5; n <= 9; n = n + 1) begin
            DOUBLE_SPEED = n[0];
            bc = n[0] ? 32 : 64;
            CHAR_SIZE = (n == 9) ? 3'h7 : n[2:0] - 3'h5;
            PARITY_MODE = {1'b1, n[1]};
            TWO_STOP = (n > 6);
            m = (9'h001 << n) - 9'h001;
            fork
                txchk(9'h1A5 ^ n[8:0], ta);
                begin
                    wr(9'h1A5 ^ n[8:0]);
                    wr(9'h05A ^ n[8:0]);
                end
            join
            txchk(9'h05A ^ n[8:0], tb2);
            `CHK("frame gap", (n + 3 + TWO_STOP) * bc, tb2 - ta)
        end
        wait_done;
        `CHK("tx done", 2'h3, {TX_DONE_IRQ, TX_EMPTY_IRQ})
        TX_DONE_CLEAR = 1'b1;
        step;
        TX_DONE_CLEAR = 1'b0;
        step;
        `CHK("tx done clear", 1'b0, TX_DONE_IRQ)
        SYNC_MODE_SELECT = 1'b1;
        TRANSFER_CLOCK_DIRECTION = 1'b1;
        DOUBLE_SPEED = 1'b0;
        BAUD_DIVISOR_HIGH = 4'h1;
        BAUD_DIVISOR_LOW = 8'h00;
        BAUD_LOW_WRITE = 1'b1;
        step;
        BAUD_LOW_WRITE = 1'b0;
        `CHK("clock drive", 1'b0, XCK_OE_N)
        wr(9'h0C3);
        xck_edge(ta);
        xck_edge(tb2);
        `CHK("clock half period", 257, tb2 - ta)
        wait_done;
        `CHK("sync done", 1'b1, TX_DONE_IRQ)
        TRANSFER_CLOCK_DIRECTION = 1'b0;
        TX_DONE_CLEAR = 1'b1;
        step;
        TX_DONE_CLEAR = 1'b0;
        `CHK("slave clock off", 1'b1, XCK_OE_N)
        wr(9'h03C);
        wait_done;
        `CHK("slave done", 1'b1, TX_DONE_IRQ)
        SYNC_MODE_SELECT = 1'b0;
        TRANSFER_CLOCK_DIRECTION = 1'b0;
        BAUD_DIVISOR_HIGH = 4'h0;
        BAUD_DIVISOR_LOW = 8'h03;
        BAUD_LOW_WRITE = 1'b1;
        step;
        BAUD_LOW_WRITE = 1'b0;
        CHAR_SIZE = 3'h3;
        PARITY_MODE = 2'h2;
        for (n = 0; n < 3; n = n + 1)
            PEER.send(9'h030 + n[8:0], 8, 2'h2, 1'b0, 1'b0, 64);
        for (n = 0; n < 3; n = n + 1)
            rd(9'h030 + n[8:0], 3'h0);
        PEER.send(9'h0A5, 8, 2'h2, 1'b0, 1'b1, 64);
        rd(9'h0A5, 3'h4);
        repeat (128) step;
        PEER.send(9'h05C, 8, 2'h2, 1'b1, 1'b0, 64);
        rd(9'h05C, 3'h2);
        for (n = 0; n < 4; n = n + 1)
            PEER.send(9'h040 + n[8:0], 8, 2'h2, 1'b0, 1'b0, 64);
        rd(9'h040, 3'h0);
        rd(9'h041, 3'h0);
        rd(9'h043, 3'h1);
        `CHK("fifo empty", 1'b0, RX_DONE_IRQ)
        DOUBLE_SPEED = 1'b1;
        PARITY_MODE = 2'h0;
        CHAR_SIZE = 3'h7;
        PEER.send(9'h1E7, 9, 2'h0, 1'b0, 1'b0, 32);
        rd(9'h1E7, 3'h0);
        summarize;
    end
    initial begin
        #3000000;
        err_count = err_count + 1;
        summarize;
    end
endmodule // tb_usart_core
